// >>> core/rbt_baseband_top.sv
// Receiver back end: bit rate divider, OOK slicer, bit synchronizer, FREQUENCY_ERROR_INDICATOR and AFC behind AXI4-Lite
// What this block does and what it requires of the transmitter and the user
// R1 - Bit rate is the oscillator clock divided by a 16-bit divisor in two bytes.
// R2 - FSK demodulator output can feed the bit synchronizer for synchronous stream.
// R3 - OOK data is sliced against a threshold chosen from three modes.
// R4 - Peak mode threshold is tracked signal strength peak minus 6 dB.
// R5 - Without signal or on zeros, peak drops one step every decay period.
// R6 - Decaying peak threshold stops at the floor threshold and holds there.
// R7 - Fixed mode compares signal strength directly against the floor threshold.
// R8 - Average mode averages signal strength; transmitter must send DC-free data.
// R9 - Bit synchronizer gives a glitch-free clock on the pin, can be disabled.
// R10 - Synchronizer is forced on in packet mode and timed from the divisor.
// R11 - Transmitter sends at least 12 bits of alternating preamble first.
// R12 - Payload has a level transition in every 16 consecutive bits.
// R13 - Transmitter and receiver bit rates differ by less than 6.5 percent.
// R14 - A launched measurement stores a signed two's complement frequency error.
// R15 - A frequency error measurement completes within four bit periods.
// R16 - Measurement is launched only while preamble is being received.
// R17 - Offset plus 20 dB bandwidth stays below the baseband filter bandwidth.
// R18 - Frequency error in hertz is synthesizer step times the signed result.
// R19 - Completed correction subtracts the correction from the carrier frequency.
// R20 - Auto enable runs correction on each receiver enable, else on launch bit.
// R21 - Auto-clear discards the previous correction first, else starts from it.
// R22 - The correction phase uses its own channel filter bandwidth setting.
// R23 - The frequency error result holds until a new measurement overwrites it.
`timescale 1ns/10ps
`include "rbt_params.svh"

module rbt_baseband_top #(
   parameter int FEI_BITS = 4,
   parameter logic [15:0] FSTEP_HZ = 16'h0001
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // AXI4-Lite register slave
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   // Demodulator side, same clock
   input wire logic FSK_DATA,
   input wire logic [7:0] RSSI_LEVEL,
   input wire logic [15:0] FREQ_OFFSET,
   input wire logic RX_ENABLE,
   // Recovered stream and radio controls
   output logic SLICED_DATA,
   output logic RECOVERED_DATA,
   output logic RECOVERED_CLOCK_PIN,
   output logic [23:0] CARRIER_FREQ,
   output logic [7:0] CHANNEL_BW_SEL,
   output logic CORRECTION_BUSY
);
   import rbt_pkg::*;

   localparam int FEI_SH = $clog2(FEI_BITS);

   rbt_state_type r_reg;
   rbt_state_type r_next;

   logic sync_en;
   logic [15:0] half;
   logic data_in;
   logic [8:0] pk_min;
   logic [8:0] step9;
   logic [7:0] thr;
   logic decay_evt;
   logic do_wr;
   logic afc_req;
   logic fei_req;
   logic afc_start;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;
   logic [19:0] acc_sum;
   logic [15:0] fei_res;
   logic [21:0] meas_bound;

   always_comb begin
      r_next = r_reg;
      sync_en = r_reg.packet_mode | ~r_reg.sync_off; // [R9] [R10]
      half = {1'b0, r_reg.div[15:1]};
      data_in = r_reg.ook ? r_reg.sliced : FSK_DATA; // [R2]
      pk_min = {1'b0, r_reg.floor} + `RBT_PEAK_6DB;
      step9 = {6'h00, r_reg.step};
      thr = r_reg.floor;
      decay_evt = r_reg.bit_tick & (r_reg.decay_cnt == r_reg.decay_per);
      do_wr = r_reg.aw_hold & r_reg.w_hold & ~r_reg.bvalid;
      afc_req = 1'b0;
      fei_req = 1'b0;
      afc_start = 1'b0;
      rd_data = 32'h00000000;
      rd_resp = `RBT_RESP_OKAY;
      acc_sum = r_reg.acc + {{4{FREQ_OFFSET[15]}}, FREQ_OFFSET};
      fei_res = 16'($signed(acc_sum) >>> FEI_SH); // [R14]
      meas_bound = 22'(FEI_BITS) * ({6'h00, r_reg.div} + {6'h00, half}) + 22'h000002;

      // Register read decode
      case (S_AXI_ARADDR)
         `RBT_OFF_DIV_HIGH: rd_data[7:0] = r_reg.div[15:8];
         `RBT_OFF_DIV_LOW: rd_data[7:0] = r_reg.div[7:0];
         `RBT_OFF_DATA_CFG: begin
            rd_data[`RBT_CFG_PACKET] = r_reg.packet_mode;
            rd_data[`RBT_CFG_SYNC_OFF] = r_reg.sync_off;
            rd_data[`RBT_CFG_OOK] = r_reg.ook;
         end
         `RBT_OFF_PEAK_CFG: begin
            rd_data[`RBT_PK_PER_LSB +: 3] = r_reg.decay_per;
            rd_data[`RBT_PK_STEP_LSB +: 3] = r_reg.step;
            rd_data[`RBT_PK_SEL_LSB +: 2] = r_reg.thr_sel;
         end
         `RBT_OFF_FLOOR: rd_data[7:0] = r_reg.floor;
         `RBT_OFF_CORR_CTRL: begin
            rd_data[`RBT_CTRL_AUTO_ON] = r_reg.auto_on;
            rd_data[`RBT_CTRL_AUTO_CLR] = r_reg.auto_clear;
            rd_data[`RBT_CTRL_AFC_DONE] = r_reg.afc_done;
            rd_data[`RBT_CTRL_FEI_DONE] = r_reg.fei_done;
            rd_data[`RBT_CTRL_BUSY] = (r_reg.st != RBT_IDLE);
         end
         `RBT_OFF_CORR_VAL: rd_data = {{16{r_reg.corr[15]}}, r_reg.corr};
         `RBT_OFF_FEI: rd_data = {{16{r_reg.frequency_error_indicator[15]}}, r_reg.frequency_error_indicator};
         `RBT_OFF_CARRIER: rd_data[23:0] = r_reg.carrier;
         `RBT_OFF_RX_BW: rd_data[7:0] = r_reg.rx_bw;
         `RBT_OFF_AFC_BW: rd_data[7:0] = r_reg.afc_bw;
         `RBT_OFF_FEI_HZ: rd_data = r_reg.fei_hz;
         default: rd_resp = `RBT_RESP_SLVERR;
      endcase

      // AXI4-Lite channel handshakes
      if (S_AXI_AWVALID && !r_reg.aw_hold && !r_reg.bvalid) begin
         r_next.aw_hold = 1'b1;
         r_next.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !r_reg.w_hold && !r_reg.bvalid) begin
         r_next.w_hold = 1'b1;
         r_next.w_data = S_AXI_WDATA;
         r_next.w_strb = S_AXI_WSTRB;
      end
      if (r_reg.bvalid && S_AXI_BREADY) begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.rvalid && S_AXI_RREADY) begin
         r_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && !r_reg.rvalid) begin
         r_next.rvalid = 1'b1;
         r_next.rdata = rd_data;
         r_next.rresp = rd_resp;
      end

      // Register writes; only lane 0 for byte registers, lanes 0 to 2 for the carrier
      if (do_wr) begin
         r_next.aw_hold = 1'b0;
         r_next.w_hold = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = `RBT_RESP_OKAY;
         case (r_reg.aw_addr)
            `RBT_OFF_DIV_HIGH: if (r_reg.w_strb[0]) r_next.div[15:8] = r_reg.w_data[7:0]; // [R1]
            `RBT_OFF_DIV_LOW: if (r_reg.w_strb[0]) r_next.div[7:0] = r_reg.w_data[7:0]; // [R1]
            `RBT_OFF_DATA_CFG: if (r_reg.w_strb[0]) begin
               r_next.packet_mode = r_reg.w_data[`RBT_CFG_PACKET];
               r_next.sync_off = r_reg.w_data[`RBT_CFG_SYNC_OFF];
               r_next.ook = r_reg.w_data[`RBT_CFG_OOK];
            end
            `RBT_OFF_PEAK_CFG: if (r_reg.w_strb[0]) begin
               r_next.decay_per = r_reg.w_data[`RBT_PK_PER_LSB +: 3];
               r_next.step = r_reg.w_data[`RBT_PK_STEP_LSB +: 3];
               r_next.thr_sel = rbt_thresh_type'(r_reg.w_data[`RBT_PK_SEL_LSB +: 2]); // [R3]
            end
            `RBT_OFF_FLOOR: if (r_reg.w_strb[0]) r_next.floor = r_reg.w_data[7:0];
            `RBT_OFF_CORR_CTRL: if (r_reg.w_strb[0]) begin
               r_next.auto_on = r_reg.w_data[`RBT_CTRL_AUTO_ON];
               r_next.auto_clear = r_reg.w_data[`RBT_CTRL_AUTO_CLR];
               afc_req = r_reg.w_data[`RBT_CTRL_AFC_LAUNCH]; // [R20]
               fei_req = r_reg.w_data[`RBT_CTRL_FEI_LAUNCH];
               if (r_reg.w_data[`RBT_CTRL_AFC_DONE]) r_next.afc_done = 1'b0;
               if (r_reg.w_data[`RBT_CTRL_FEI_DONE]) r_next.fei_done = 1'b0;
            end
            `RBT_OFF_CARRIER: begin
               for (int i = 0; i < 3; i++) begin
                  if (r_reg.w_strb[i]) r_next.carrier[i*8 +: 8] = r_reg.w_data[i*8 +: 8];
               end
            end
            `RBT_OFF_RX_BW: if (r_reg.w_strb[0]) r_next.rx_bw = r_reg.w_data[7:0];
            `RBT_OFF_AFC_BW: if (r_reg.w_strb[0]) r_next.afc_bw = r_reg.w_data[7:0];
            `RBT_OFF_CORR_VAL, `RBT_OFF_FEI, `RBT_OFF_FEI_HZ: r_next.bresp = `RBT_RESP_OKAY;
            default: r_next.bresp = `RBT_RESP_SLVERR;
         endcase
      end

      // Bit synchronizer: re-phase on each edge, sample at the middle of the bit
      r_next.data_q = data_in;
      r_next.bit_tick = 1'b0;
      if (data_in != r_reg.data_q) begin // [R13]
         r_next.ph_cnt = half;
      end else if (r_reg.ph_cnt >= r_reg.div - 16'h0001) begin // [R1] [R10]
         r_next.ph_cnt = 16'h0000;
         r_next.bit_tick = 1'b1;
         r_next.bit_data = r_reg.data_q;
      end else begin
         r_next.ph_cnt = r_reg.ph_cnt + 16'h0001;
      end
      r_next.dclk = sync_en & (r_next.ph_cnt >= half); // [R9]

      // OOK slicer threshold
      case (r_reg.thr_sel)
         RBT_TH_FIXED: thr = r_reg.floor; // [R7]
         RBT_TH_AVG: thr = r_reg.avg[11:`RBT_AVG_SHIFT]; // [R8]
         default: thr = (!pk_min[8] && r_reg.peak > pk_min[7:0]) ? r_reg.peak - pk_min[7:0] + r_reg.floor
                        : r_reg.floor; // [R4] [R6]
      endcase
      r_next.sliced = RSSI_LEVEL > thr; // [R3]
      r_next.avg = r_reg.avg - {4'h0, r_reg.avg[11:`RBT_AVG_SHIFT]} + {4'h0, RSSI_LEVEL}; // [R8]
      if (r_reg.bit_tick) begin
         r_next.decay_cnt = (r_reg.decay_cnt == r_reg.decay_per) ? 3'h0 : r_reg.decay_cnt + 3'h1;
      end
      if (RSSI_LEVEL > r_reg.peak) begin
         r_next.peak = RSSI_LEVEL; // [R4]
      end else if (decay_evt && !r_reg.sliced) begin
         if ({1'b0, r_reg.peak} >= pk_min + step9) begin
            r_next.peak = r_reg.peak - {5'h00, r_reg.step}; // [R5]
         end else if ({1'b0, r_reg.peak} > pk_min) begin
            r_next.peak = pk_min[7:0]; // [R6]
         end
      end

      // Frequency error measurement and correction sequence
      r_next.rx_en_q = RX_ENABLE;
      afc_start = afc_req | (r_reg.auto_on & RX_ENABLE & ~r_reg.rx_en_q); // [R20]
      r_next.meas_cyc = (r_reg.st == RBT_MEAS) ? r_reg.meas_cyc + 22'h000001 : 22'h000000;
      unique case (r_reg.st)
         RBT_IDLE: begin
            r_next.acc = 20'h00000;
            r_next.meas_cnt = 3'h0;
            if (afc_start) begin
               r_next.afc_run = 1'b1;
               r_next.fei_only = 1'b0;
               r_next.st = (r_reg.auto_on && r_reg.auto_clear && !afc_req) ? RBT_CLEAR : RBT_MEAS; // [R21]
            end else if (fei_req) begin
               r_next.fei_only = 1'b1;
               r_next.st = RBT_MEAS;
            end
         end
         RBT_CLEAR: begin
            r_next.carrier = r_reg.carrier + {{8{r_reg.corr[15]}}, r_reg.corr}; // [R21]
            r_next.corr = 16'h0000;
            r_next.st = RBT_MEAS;
         end
         RBT_MEAS: begin
            if (r_reg.bit_tick) begin
               r_next.acc = acc_sum;
               r_next.meas_cnt = r_reg.meas_cnt + 3'h1;
               if (r_reg.meas_cnt == 3'(FEI_BITS - 1)) begin // [R15]
                  r_next.frequency_error_indicator = fei_res; // [R14] [R23]
                  r_next.fei_hz = 32'($signed(fei_res) * $signed({1'b0, FSTEP_HZ})); // [R18]
                  r_next.st = RBT_APPLY;
               end
            end
         end
         RBT_APPLY: begin
            if (!r_reg.fei_only) begin
               r_next.carrier = r_reg.carrier - {{8{r_reg.frequency_error_indicator[15]}}, r_reg.frequency_error_indicator}; // [R19]
               r_next.corr = r_reg.corr + r_reg.frequency_error_indicator;
               r_next.afc_done = 1'b1;
            end
            r_next.fei_done = 1'b1;
            r_next.afc_run = 1'b0;
            r_next.st = RBT_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r_reg <= '0;
         r_reg.div <= `RBT_RST_DIV;
         r_reg.floor <= `RBT_RST_FLOOR;
         r_reg.step <= `RBT_RST_STEP;
         r_reg.decay_per <= `RBT_RST_PER;
         r_reg.thr_sel <= RBT_TH_PEAK;
         r_reg.rx_bw <= `RBT_RST_RX_BW;
         r_reg.afc_bw <= `RBT_RST_AFC_BW;
         r_reg.carrier <= `RBT_RST_CARRIER;
         r_reg.st <= RBT_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign S_AXI_AWREADY = ~r_reg.aw_hold & ~r_reg.bvalid;
   assign S_AXI_WREADY = ~r_reg.w_hold & ~r_reg.bvalid;
   assign S_AXI_BVALID = r_reg.bvalid;
   assign S_AXI_BRESP = r_reg.bresp;
   assign S_AXI_ARREADY = ~r_reg.rvalid;
   assign S_AXI_RVALID = r_reg.rvalid;
   assign S_AXI_RDATA = r_reg.rdata;
   assign S_AXI_RRESP = r_reg.rresp;
   assign SLICED_DATA = r_reg.sliced;
   assign RECOVERED_DATA = sync_en ? r_reg.bit_data : r_reg.data_q; // [R2]
   assign RECOVERED_CLOCK_PIN = r_reg.dclk;
   assign CARRIER_FREQ = r_reg.carrier;
   assign CHANNEL_BW_SEL = r_reg.afc_run ? r_reg.afc_bw : r_reg.rx_bw; // [R22]
   assign CORRECTION_BUSY = (r_reg.st != RBT_IDLE);

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   sequence seq_measure_done;
      (r_reg.st == RBT_MEAS) ##1 (r_reg.st == RBT_APPLY);
   endsequence

   sequence seq_correction;
      seq_measure_done ##0 !r_reg.fei_only;
   endsequence

   AST_CLOCK_OFF: assert property (!r_reg.packet_mode && r_reg.sync_off |=> !RECOVERED_CLOCK_PIN) // [R9]
      else $error("recovered clock active while synchronizer disabled");
   AST_PACKET_DATA: assert property (r_reg.packet_mode ##1 r_reg.packet_mode && !r_reg.bit_tick // [R10]
      |-> $stable(RECOVERED_DATA))
      else $error("packet data changed away from a bit sample");
   AST_PEAK_TRACK: assert property (r_reg.thr_sel == RBT_TH_PEAK && RSSI_LEVEL > r_reg.peak
      |=> r_reg.peak == $past(RSSI_LEVEL)) // [R4]
      else $error("peak did not follow a higher signal strength");
   AST_PEAK_DECAY: assert property (RSSI_LEVEL <= r_reg.peak && decay_evt && !r_reg.sliced
      && {1'b0, r_reg.peak} >= pk_min + step9 |=> r_reg.peak == $past(r_reg.peak) - {5'h00, $past(r_reg.step)}) // [R5]
      else $error("peak did not fall by one step");
   AST_FLOOR_HOLD: assert property (r_reg.thr_sel == RBT_TH_PEAK |-> thr >= r_reg.floor) // [R6]
      else $error("peak threshold fell below the floor");
   AST_FIXED_SLICE: assert property (r_reg.thr_sel == RBT_TH_FIXED
      |=> SLICED_DATA == ($past(RSSI_LEVEL) > $past(r_reg.floor))) // [R7]
      else $error("fixed threshold slicing wrong");
   AST_MEAS_BOUND: assert property (r_reg.st == RBT_MEAS |-> r_reg.meas_cyc <= meas_bound) // [R15]
      else $error("frequency error measurement took too long");
   AST_CARRIER_SUB: assert property (seq_correction |=> CARRIER_FREQ == $past(r_reg.carrier) - {{8{$past(r_reg.frequency_error_indicator[15])}},
      $past(r_reg.frequency_error_indicator)}) // [R19]
      else $error("carrier not corrected by the measured error");
   AST_AUTO_START: assert property (r_reg.st == RBT_IDLE && r_reg.auto_on && RX_ENABLE && !r_reg.rx_en_q
      |=> CORRECTION_BUSY) // [R20]
      else $error("automatic correction did not start on receiver enable");
   AST_AUTO_CLEAR: assert property (r_reg.st == RBT_CLEAR // [R21]
      |=> r_reg.corr == 16'h0000 && r_reg.st == RBT_MEAS)
      else $error("previous correction not discarded");
   AST_AFC_BW: assert property (CORRECTION_BUSY && !r_reg.fei_only |-> CHANNEL_BW_SEL == r_reg.afc_bw) // [R22]
      else $error("correction bandwidth not applied");
   AST_FEI_HOLD: assert property (r_reg.st == RBT_IDLE ##1 r_reg.st == RBT_IDLE |-> $stable(r_reg.frequency_error_indicator)) // [R23]
      else $error("frequency error result changed while idle");
   AST_FEI_HZ: assert property (seq_measure_done |-> r_reg.fei_hz == 32'($signed(r_reg.frequency_error_indicator) * $signed({1'b0, FSTEP_HZ})))
      // [R18]
      else $error("hertz error not step times result");

   // A data edge re-centres the sample point, so a small rate mismatch never accumulates
   AST_REPHASE: assert property (data_in != r_reg.data_q |=> r_reg.ph_cnt == $past(half)) // [R13]
      else $error("synchronizer phase not re-centred on a data edge");

   // Responses stand until the master takes them
   AST_BRESP_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped before it was taken");

   AST_RDATA_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped before it was taken");

endmodule : rbt_baseband_top

// >>> core/rbt_params.svh
// Register offsets, field positions, reset values and fixed levels of the receiver back end
`ifndef RBT_PARAMS_SVH
`define RBT_PARAMS_SVH
`define RBT_OFF_DIV_HIGH 8'h00
`define RBT_OFF_DIV_LOW 8'h04
`define RBT_OFF_DATA_CFG 8'h08
`define RBT_OFF_PEAK_CFG 8'h0c
`define RBT_OFF_FLOOR 8'h10
`define RBT_OFF_CORR_CTRL 8'h14
`define RBT_OFF_CORR_VAL 8'h18
`define RBT_OFF_FEI 8'h1c
`define RBT_OFF_CARRIER 8'h20
`define RBT_OFF_RX_BW 8'h24
`define RBT_OFF_AFC_BW 8'h28
`define RBT_OFF_FEI_HZ 8'h2c
`define RBT_CFG_PACKET 0
`define RBT_CFG_SYNC_OFF 1
`define RBT_CFG_OOK 2
`define RBT_PK_PER_LSB 0
`define RBT_PK_STEP_LSB 3
`define RBT_PK_SEL_LSB 6
`define RBT_CTRL_AFC_LAUNCH 0
`define RBT_CTRL_FEI_LAUNCH 1
`define RBT_CTRL_AUTO_ON 2
`define RBT_CTRL_AUTO_CLR 3
`define RBT_CTRL_AFC_DONE 4
`define RBT_CTRL_FEI_DONE 5
`define RBT_CTRL_BUSY 6
`define RBT_RST_DIV 16'h1a0b
`define RBT_RST_FLOOR 8'h0c
`define RBT_RST_STEP 3'h0
`define RBT_RST_PER 3'h0
`define RBT_RST_RX_BW 8'h55
`define RBT_RST_AFC_BW 8'h8b
`define RBT_RST_CARRIER 24'h800000
`define RBT_PEAK_6DB 9'h00c
`define RBT_AVG_SHIFT 4
`define RBT_RESP_OKAY 2'b00
`define RBT_RESP_SLVERR 2'b10
`endif

// >>> core/rbt_pkg.sv
// Types of the receiver baseband timing and frequency correction block
package rbt_pkg;
   typedef enum logic [1:0] {
      RBT_IDLE = 2'b00,
      RBT_CLEAR = 2'b01,
      RBT_MEAS = 2'b11,
      RBT_APPLY = 2'b10
   } rbt_afc_state_type;

   typedef enum logic [1:0] {
      RBT_TH_PEAK = 2'b00,
      RBT_TH_FIXED = 2'b01,
      RBT_TH_AVG = 2'b10
   } rbt_thresh_type;

   typedef struct packed {
      logic aw_hold;
      logic [7:0] aw_addr;
      logic w_hold;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] div;
      logic packet_mode;
      logic sync_off;
      logic ook;
      rbt_thresh_type thr_sel;
      logic [2:0] step;
      logic [2:0] decay_per;
      logic [7:0] floor;
      logic auto_on;
      logic auto_clear;
      logic afc_done;
      logic fei_done;
      logic [23:0] carrier;
      logic [15:0] corr;
      logic [15:0] frequency_error_indicator;
      logic [31:0] fei_hz;
      logic [7:0] rx_bw;
      logic [7:0] afc_bw;
      logic [15:0] ph_cnt;
      logic data_q;
      logic bit_data;
      logic dclk;
      logic bit_tick;
      logic [7:0] peak;
      logic [11:0] avg;
      logic [2:0] decay_cnt;
      logic sliced;
      rbt_afc_state_type st;
      logic [19:0] acc;
      logic [2:0] meas_cnt;
      logic [21:0] meas_cyc;
      logic rx_en_q;
      logic afc_run;
      logic fei_only;
   } rbt_state_type;
endpackage : rbt_pkg

// >>> tb/rbt_tx_model.sv
// Remote transmitter model feeding the demodulator side of the receiver back end
`timescale 1ns/10ps

module rbt_tx_model #(
   parameter int BP = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Controls from the bench
   input wire logic en,
   input wire logic [7:0] hi,
   input wire logic [15:0] off,
   // Demodulator side
   output logic fsk_data,
   output logic [7:0] rssi,
   output logic [15:0] freq
);
   logic [7:0] cnt;
   logic bitv;

   // Alternating stream at the receiver's own rate: preamble, a transition every bit, DC-free
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 8'h00;
         bitv <= 1'b0;
      end else if (cnt == 8'(BP - 1)) begin
         cnt <= 8'h00;
         bitv <= ~bitv;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   // Silent carrier: null strength, no offset, data line shows the inverse level
   assign fsk_data = en ? bitv : ~bitv;
   assign rssi = (en && bitv) ? hi : 8'h00;
   assign freq = en ? off : 16'h0000;
endmodule : rbt_tx_model

// >>> tb/tb.sv
// Self-checking bench for the receiver back end over AXI4-Lite
`timescale 1ns/10ps

module tb;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic rx = 1'b0, en = 1'b0;
   logic [3:0] strb = 4'hf;
   int flips = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, hi = 8'h00, rssi, bw;
   logic [31:0] wdata = 32'h0, rdata;
   logic [15:0] off = 16'h0000, freq;
   logic awready, wready, bvalid, arready, rvalid, fsk, sliced, rdat, rclk, busy;
   logic [1:0] bresp, rresp;
   logic [23:0] carrier;
   int err_count = 0, checks_done = 0;
   logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'h24, 8'h28};
   logic [31:0] rv[6] = '{32'h1a, 32'h0b, 32'h0c, 32'h800000, 32'h55, 32'h8b};
   logic [7:0] tc[9] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h38, 8'h38, 8'h38, 8'h80};
   logic [7:0] th[9] = '{8'h0d, 8'h0c, 8'h40, 8'h35, 8'h33, 8'h00, 8'h0d, 8'h0c, 8'h40};
   logic tp[9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

   always #20 clk = ~clk;

   rbt_baseband_top #(.FEI_BITS(4), .FSTEP_HZ(16'h0003)) DUT (
      .CLK(clk), .RST(rst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .FSK_DATA(fsk), .RSSI_LEVEL(rssi), .FREQ_OFFSET(freq),
      .RX_ENABLE(rx), .SLICED_DATA(sliced), .RECOVERED_DATA(rdat), .RECOVERED_CLOCK_PIN(rclk),
      .CARRIER_FREQ(carrier), .CHANNEL_BW_SEL(bw), .CORRECTION_BUSY(busy));
   rbt_tx_model #(.BP(16)) TX (.clk(clk), .rst(rst), .en(en), .hi(hi), .off(off), .fsk_data(fsk),
      .rssi(rssi), .freq(freq));

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tmo;
      chk("handshake", 32'h0, 32'h1);
      conclude();
   endtask : tmo

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ok, ta, tw;
      logic [1:0] r;
      ok = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 100 && !ok; i++) begin
         @(negedge clk);
         ta = awv && awready === 1'b1;
         tw = wv && wready === 1'b1;
         ok = (bvalid === 1'b1);
         r = bresp;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      bready <= 1'b0;
      if (!ok) tmo();
      chk("write response", 32'(r), 32'(er));
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ok, ta;
      ok = 1'b0;
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 100 && !ok; i++) begin
         @(negedge clk);
         ta = arv && arready === 1'b1;
         ok = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end
      rready <= 1'b0;
      if (!ok) tmo();
   endtask : rd

   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(nm, d & m, e);
   endtask : rc

   // Counts sliced ones and rising edges of the recovered clock
   task automatic mon(input int n, output int ones, output int rises);
      logic p, q;
      ones = 0;
      rises = 0;
      flips = 0;
      p = rclk;
      q = rdat;
      repeat (n) begin
         @(negedge clk);
         if (sliced === 1'b1) ones++;
         if (rclk === 1'b1 && p === 1'b0) rises++;
         if (rdat !== q) flips++;
         p = rclk;
         q = rdat;
      end
   endtask : mon

   task automatic waitdone(input logic afc);
      int n;
      logic s;
      n = 0;
      s = 1'b0;
      for (int i = 0; i < 200; i++) begin
         @(negedge clk);
         if (busy === 1'b1) begin
            s = 1'b1;
            n++;
            if (afc && n == 2) chk("afc bandwidth", 32'(bw), 32'h8b);
         end else if (s) begin
            break;
         end
      end
      if (busy === 1'b1 || !s) tmo();
      chk("busy length", 32'(n <= 70), 32'h1);
   endtask : waitdone

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int ones, rises;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 6; k++) rc("reset value", ra[k], rv[k], 32'hffffffff);
      rd(8'h30, d, r);
      chk("unmapped data", d, 32'h0);
      chk("unmapped resp", 32'(r), 32'h2);
      wr(8'h34, 32'h1, 2'b10);
      wr(8'h1c, 32'h1234, 2'b00);
      rc("read-only result", 8'h1c, 32'h0, 32'hffff);
      wr(8'h00, 32'h0, 2'b00);
      wr(8'h04, 32'h10, 2'b00);
      rc("divisor low", 8'h04, 32'h10, 32'hffffffff);
      en <= 1'b1;
      off <= 16'hffe0;
      mon(320, ones, rises);
      chk("clock rises", 32'(rises >= 18 && rises <= 21), 32'h1);
      chk("data flips", 32'(flips >= 18 && flips <= 21), 32'h1);
      wr(8'h08, 32'h2, 2'b00);
      mon(320, ones, rises);
      chk("clock disabled", 32'(rises), 32'h0);
      wr(8'h08, 32'h3, 2'b00);
      mon(320, ones, rises);
      chk("packet clock", 32'(rises >= 18 && rises <= 21), 32'h1);
      wr(8'h08, 32'h0, 2'b00);
      wr(8'h14, 32'h2, 2'b00);
      waitdone(1'b0);
      rc("fei result", 8'h1c, 32'hffe0, 32'hffff);
      rc("fei hertz", 8'h2c, 32'hffffffa0, 32'hffffffff);
      wr(8'h14, 32'h1, 2'b00);
      waitdone(1'b1);
      rc("carrier afc", 8'h20, 32'h800020, 32'hffffffff);
      rc("correction", 8'h18, 32'hffe0, 32'hffff);
      chk("bandwidth after", 32'(bw), 32'h55);
      off <= 16'hfff0;
      rx <= 1'b1;
      repeat (4) @(posedge clk);
      chk("no auto run", 32'(busy), 32'h0);
      rc("result held", 8'h1c, 32'hffe0, 32'hffff);
      rx <= 1'b0;
      wr(8'h14, 32'h4, 2'b00);
      rx <= 1'b1;
      waitdone(1'b1);
      chk("auto carrier", 32'(carrier), 32'h800030);
      rx <= 1'b0;
      wr(8'h14, 32'hc, 2'b00);
      rx <= 1'b1;
      waitdone(1'b1);
      chk("cleared carrier", 32'(carrier), 32'h800010);
      rc("cleared correction", 8'h18, 32'hfff0, 32'hffff);
      rx <= 1'b0;
      for (int k = 0; k < 9; k++) begin
         hi <= th[k];
         wr(8'h0c, 32'(tc[k]), 2'b00);
         mon(256, ones, rises);
         chk("slicer ones", 32'(ones > 0), 32'(tp[k]));
      end
      strb <= 4'h1;
      wr(8'h20, 32'h00ffffff, 2'b00);
      rc("carrier lane", 8'h20, 32'h8000ff, 32'hffffffff);
      conclude();
   end
endmodule : tb
